// [remappable_output_pin_select_tb_top.sv]
/* self-checking bench for the output pin select.
  assumes the peripheral model and bench both drive right after the rising edge. */
`include "rops_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module remappable_output_pin_select_tb_top;
  logic                      clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
  logic [`ROPS_ADDR_W-1:0]   addr = 4'h0;
  logic [`ROPS_DATA_W-1:0]   wdata = 16'h0000, rdata, d;
  logic [`ROPS_NUM_PINS-1:0] pin, act;
  logic [5:0]                lo, hi;
  logic [28:0]               p;
  rops_pkg::rops_periph_s    periph;
  int                        mismatches = 0, compares = 0;
  // row per code: expected source bit, -1 for null and unused codes; codes above 36 are unused
  int src_map [37] = '{-1, 26, 27, 22, 18, 23, 19, 15, 12, 9, 16, 13, 10, -1, -1, -1, -1, -1, 0, 1, 2, 3, 4, 5,
    6, 7, -1, -1, 24, 20, 25, 21, 17, 14, 11, 8, 28};
  always #12.5 clk = ~clk;
  rops_periph_model peer (.clk_i(clk), .rst_i(rst), .periph_o(periph));
  rops_output_select dut (.SYS_CLK_I(clk), .SYS_RST_I(rst), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
    .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .PERIPH_I(periph), .PIN_OUT_O(pin), .PIN_ACTIVE_O(act));
  function automatic logic exp_pin(logic [5:0] c, logic [28:0] v);
    return (c < 37 && src_map[c] >= 0) ? v[src_map[c]] : 1'b0;
  endfunction
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr_reg(logic [3:0] a, logic [15:0] v);
    addr <= a; wdata <= v; wr <= 1'b1;
    @(posedge clk) wr <= 1'b0;
  endtask
  task automatic rd_reg(logic [3:0] a, output logic [15:0] v);
    addr <= a; rd <= 1'b1;
    @(posedge clk) rd <= 1'b0;
    @(posedge clk) v = rdata;
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (4000) @(posedge clk);
    mismatches++;
    $display("watchdog expired");
    close_out;
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int c = 0; c < 64; c++) begin
      lo = 6'(c);
      hi = 6'(63 - c);
      wr_reg(4'(c), {2'b11, hi, 2'b11, lo});
      @(posedge clk) p = periph;
      #1;
      chk("pin even", 32'(exp_pin(lo, p)), 32'(pin[2 * (c % 16)]));
      chk("pin odd", 32'(exp_pin(hi, p)), 32'(pin[2 * (c % 16) + 1]));
      chk("enable pair", 32'({|hi, |lo}), 32'(act[2 * (c % 16) +: 2]));
      @(posedge clk);
      rd_reg(4'(c), d);
      chk("read back", 32'({2'b00, hi, 2'b00, lo}), 32'(d));
    end
    $display("code table done");
    wr_reg(4'h0, 16'h2401);
    rd_reg(4'h0, d);
    chk("back to back read", 32'h2401, 32'(d));
    wr_reg(4'h0, 16'h000D);
    repeat (2) @(posedge clk);
    #1 chk("unused code pin", 32'h0, 32'(pin[0]));
    $display("back to back done");
    @(posedge clk) rst <= 1'b1;
    @(posedge clk) rst <= 1'b0;
    rd_reg(4'hF, d);
    #1 chk("pins after reset", 32'h0, pin);
    chk("enables after reset", 32'h0, act);
    chk("selector after reset", 32'h0, 32'(d));
    $display("mid-run reset done");
    close_out;
  end
endmodule
`default_nettype wire

// [rops_defs.svh]
/*
  register count and widths, field positions, reset values and selector codes
  for the remappable output pin select block.
  assumes a 16-bit register port with one register per address.
*/
`ifndef ROPS_DEFS_SVH
`define ROPS_DEFS_SVH

`define ROPS_NUM_PINS      32
`define ROPS_NUM_REGS      16
`define ROPS_ADDR_W        4
`define ROPS_DATA_W        16
`define ROPS_SEL_W         6
`define ROPS_HI_LSB        8
`define ROPS_HI_MSB        13
`define ROPS_LO_LSB        0
`define ROPS_LO_MSB        5
`define ROPS_SEL_RESET     6'h00
`define ROPS_NUM_SOURCES   64

`define ROPS_CODE_NULL     6'h00
`define ROPS_CODE_CMP1     6'h01
`define ROPS_CODE_CMP2     6'h02
`define ROPS_CODE_U1_TX    6'h03
`define ROPS_CODE_U1_RTS   6'h04
`define ROPS_CODE_U2_TX    6'h05
`define ROPS_CODE_U2_RTS   6'h06
`define ROPS_CODE_S1_DO    6'h07
`define ROPS_CODE_S1_CK    6'h08
`define ROPS_CODE_S1_SS    6'h09
`define ROPS_CODE_S2_DO    6'h0A
`define ROPS_CODE_S2_CK    6'h0B
`define ROPS_CODE_S2_SS    6'h0C
`define ROPS_CODE_OC_FIRST 6'h12
`define ROPS_CODE_U3_TX    6'h1C
`define ROPS_CODE_U3_RTS   6'h1D
`define ROPS_CODE_U4_TX    6'h1E
`define ROPS_CODE_U4_RTS   6'h1F
`define ROPS_CODE_S3_DO    6'h20
`define ROPS_CODE_S3_CK    6'h21
`define ROPS_CODE_S3_SS    6'h22
`define ROPS_CODE_OC9      6'h23
`define ROPS_CODE_CMP3     6'h24

`endif

// [rops_output_select.sv]
/*
  remappable output pin select: sixteen 16-bit mapping registers, two
  6-bit selectors each, steering peripheral outputs onto 32 pins.
  assumes synchronous peripheral outputs and a single-cycle register port
  with read data one cycle after the read strobe.
*/
// The strobed register port and the address map were chosen for this implementation.
// Function
// - every remappable pin has its own selector choosing its peripheral output.
// - each mapping register holds two 6-bit selectors, one per pin.
// - selector value names a function whose output then drives the pin.
// - code zero is null; pin is driven by no peripheral output.
// - code 1 routes comparator one, code 2 comparator two.
// - codes 3-6 and 28-31 select uart transmit then request-to-send.
// - codes 7-12 and 32-34 select spi data, clock, select outputs.
// - codes 18-25 select compare channels 1-8; code 35 channel 9.
// - code 36 selects comparator three; codes 37-63 leave pin unconnected.
// - reset clears every selector to null.
// - higher pin in bits 13-8, lower in 5-0, rest read zero.
`include "rops_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module rops_output_select (
  input  wire logic                          SYS_CLK_I,
  input  wire logic                          SYS_RST_I,
  input  wire logic [`ROPS_ADDR_W-1:0]       REG_ADDR_I,
  input  wire logic [`ROPS_DATA_W-1:0]       REG_WDATA_I,
  input  wire logic                          REG_WR_I,
  input  wire logic                          REG_RD_I,
  output logic [`ROPS_DATA_W-1:0]            REG_RDATA_O,
  input  wire rops_pkg::rops_periph_s        PERIPH_I,
  output logic [`ROPS_NUM_PINS-1:0]          PIN_OUT_O,
  output logic [`ROPS_NUM_PINS-1:0]          PIN_ACTIVE_O
);

  rops_pkg::rops_sel_t             sel_reg  [`ROPS_NUM_PINS];
  rops_pkg::rops_sel_t             sel_next [`ROPS_NUM_PINS];
  logic [`ROPS_DATA_W-1:0]         rdata_reg;
  logic [`ROPS_DATA_W-1:0]         rdata_next;
  logic [`ROPS_NUM_SOURCES-1:0]    src;
  logic [`ROPS_NUM_PINS-1:0]       pin_mux;
  logic [`ROPS_NUM_PINS-1:0]       pin_act;
  logic [`ROPS_NUM_PINS-1:0]       pin_reg;
  logic [`ROPS_NUM_PINS-1:0]       act_reg;

  // source vector indexed by code; anything not listed stays low
  always_comb begin
    src                         = '0;
    src[`ROPS_CODE_CMP1]        = PERIPH_I.comparator_one_out;
    src[`ROPS_CODE_CMP2]        = PERIPH_I.comparator_two_out;
    src[`ROPS_CODE_U1_TX]       = PERIPH_I.uart_transmit[0];
    src[`ROPS_CODE_U1_RTS]      = PERIPH_I.uart_request_to_send[0];
    src[`ROPS_CODE_U2_TX]       = PERIPH_I.uart_transmit[1];
    src[`ROPS_CODE_U2_RTS]      = PERIPH_I.uart_request_to_send[1];
    src[`ROPS_CODE_U3_TX]       = PERIPH_I.uart_transmit[2];
    src[`ROPS_CODE_U3_RTS]      = PERIPH_I.uart_request_to_send[2];
    src[`ROPS_CODE_U4_TX]       = PERIPH_I.uart_transmit[3];
    src[`ROPS_CODE_U4_RTS]      = PERIPH_I.uart_request_to_send[3];
    src[`ROPS_CODE_S1_DO]       = PERIPH_I.spi_data_out[0];
    src[`ROPS_CODE_S1_CK]       = PERIPH_I.spi_clock_out[0];
    src[`ROPS_CODE_S1_SS]       = PERIPH_I.spi_select_out[0];
    src[`ROPS_CODE_S2_DO]       = PERIPH_I.spi_data_out[1];
    src[`ROPS_CODE_S2_CK]       = PERIPH_I.spi_clock_out[1];
    src[`ROPS_CODE_S2_SS]       = PERIPH_I.spi_select_out[1];
    src[`ROPS_CODE_S3_DO]       = PERIPH_I.spi_data_out[2];
    src[`ROPS_CODE_S3_CK]       = PERIPH_I.spi_clock_out[2];
    src[`ROPS_CODE_S3_SS]       = PERIPH_I.spi_select_out[2];
    for (int k = 0; k < 8; k++) begin
      src[`ROPS_CODE_OC_FIRST + k[5:0]] = PERIPH_I.compare_channel[k];
    end
    src[`ROPS_CODE_OC9]         = PERIPH_I.compare_channel[8];
    src[`ROPS_CODE_CMP3]        = PERIPH_I.comparator_three_out;
  end

  // register writes and read-back; odd pin in the high field
  always_comb begin
    for (int p = 0; p < `ROPS_NUM_PINS; p++) begin
      sel_next[p] = sel_reg[p];
    end
    if (REG_WR_I) begin
      sel_next[{REG_ADDR_I, 1'b1}] = REG_WDATA_I[`ROPS_HI_MSB:`ROPS_HI_LSB];
      sel_next[{REG_ADDR_I, 1'b0}] = REG_WDATA_I[`ROPS_LO_MSB:`ROPS_LO_LSB];
    end
    rdata_next = '0;
    if (REG_RD_I) begin
      rdata_next[`ROPS_HI_MSB:`ROPS_HI_LSB] = sel_reg[{REG_ADDR_I, 1'b1}];
      rdata_next[`ROPS_LO_MSB:`ROPS_LO_LSB] = sel_reg[{REG_ADDR_I, 1'b0}];
    end
  end

  always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      for (int p = 0; p < `ROPS_NUM_PINS; p++) begin
        sel_reg[p] <= `ROPS_SEL_RESET;
      end
      rdata_reg <= 16'h0000;
    end else begin
      for (int p = 0; p < `ROPS_NUM_PINS; p++) begin
        sel_reg[p] <= sel_next[p];
      end
      rdata_reg <= rdata_next;
    end
  end

  // one mux per pin
  genvar g;
  generate
    for (g = 0; g < `ROPS_NUM_PINS; g++) begin : g_pin
      rops_pin_mux u_mux (
        .src_i    (src),
        .sel_i    (sel_reg[g]),
        .pin_o    (pin_mux[g]),
        .active_o (pin_act[g])
      );
    end
  endgenerate

  // pins registered so they are glitch free; costs one cycle of latency
  always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      pin_reg <= 32'h0000_0000;
      act_reg <= 32'h0000_0000;
    end else begin
      pin_reg <= pin_mux;
      act_reg <= pin_act;
    end
  end

  assign REG_RDATA_O  = rdata_reg;
  assign PIN_OUT_O    = pin_reg;
  assign PIN_ACTIVE_O = act_reg;

endmodule

`default_nettype wire

// [rops_output_select_properties.sv]
/* port checker for the output pin select.
  assumes strobes one cycle long and a single clock domain. */
`include "rops_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module rops_output_select_properties (
  input wire logic                      SYS_CLK_I,
  input wire logic                      SYS_RST_I,
  input wire logic [`ROPS_ADDR_W-1:0]   REG_ADDR_I,
  input wire logic [`ROPS_DATA_W-1:0]   REG_WDATA_I,
  input wire logic                      REG_WR_I,
  input wire logic                      REG_RD_I,
  input wire logic [`ROPS_DATA_W-1:0]   REG_RDATA_O,
  input wire rops_pkg::rops_periph_s    PERIPH_I,
  input wire logic [`ROPS_NUM_PINS-1:0] PIN_OUT_O,
  input wire logic [`ROPS_NUM_PINS-1:0] PIN_ACTIVE_O
);
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (SYS_RST_I);
  reserved_zero_a: assert property (REG_RDATA_O[15:14] == 2'h0 && REG_RDATA_O[7:6] == 2'h0)
    else $error("reserved read bits set");
  null_pin_low_a: assert property ((PIN_OUT_O & ~PIN_ACTIVE_O) == '0)
    else $error("inactive pin driven high");
  reset_clear_a: assert property ($fell(SYS_RST_I) |-> PIN_OUT_O == '0 && PIN_ACTIVE_O == '0)
    else $error("pins not clear after reset");
  write_readback_a: assert property (REG_WR_I ##1 (REG_RD_I && REG_ADDR_I == $past(REG_ADDR_I))
    |=> REG_RDATA_O == ($past(REG_WDATA_I, 2) & 16'h3F3F)) else $error("read back differs from write");
  active_map_a: assert property (REG_WR_I && REG_ADDR_I == 4'h0 ##1 !(REG_WR_I && REG_ADDR_I == 4'h0)
    |=> PIN_ACTIVE_O[1:0] == {|$past(REG_WDATA_I[13:8], 2), |$past(REG_WDATA_I[5:0], 2)})
    else $error("pin enable does not follow selector");
  cmp_one_route_a: assert property (REG_WR_I && REG_ADDR_I == 4'h0 && REG_WDATA_I[5:0] == 6'h01
    ##1 !(REG_WR_I && REG_ADDR_I == 4'h0) |=> PIN_OUT_O[0] == $past(PERIPH_I.comparator_one_out))
    else $error("comparator one not on pin 0");
  unused_quiet_a: assert property (REG_WR_I && REG_ADDR_I == 4'h0
    && REG_WDATA_I[5:0] inside {[6'h0D:6'h11], 6'h1A, 6'h1B, [6'h25:6'h3F]}
    ##1 !(REG_WR_I && REG_ADDR_I == 4'h0) |=> !PIN_OUT_O[0]) else $error("unused code drives pin 0");
  active_hold_a: assert property (!$past(REG_WR_I, 2) |-> $stable(PIN_ACTIVE_O))
    else $error("pin enable moved without a write");
endmodule
bind rops_output_select rops_output_select_properties u_props (.SYS_CLK_I, .SYS_RST_I, .REG_ADDR_I,
  .REG_WDATA_I, .REG_WR_I, .REG_RD_I, .REG_RDATA_O, .PERIPH_I, .PIN_OUT_O, .PIN_ACTIVE_O);
`default_nettype wire

// [rops_periph_model.sv]
/* far-side model: peripheral output levels.
  assumes one clock; levels change only after a rising edge. */
`timescale 1ns/1ps
`default_nettype none
module rops_periph_model (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  output var rops_pkg::rops_periph_s periph_o
);
  // twisted ring: every source toggles, each at its own phase, so a wrong route shows
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      periph_o <= 29'h0F0F0F0F;
    end else begin
      periph_o <= {periph_o[27:0], ~periph_o[28]};
    end
  end
endmodule
`default_nettype wire

// [rops_pin_mux.sv]
/*
  one remappable pin: selector code to peripheral output.
  assumes the source vector is indexed by selector code, with unused codes tied low.
*/
`include "rops_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module rops_pin_mux (
  input  wire logic [`ROPS_NUM_SOURCES-1:0] src_i,
  input  wire rops_pkg::rops_sel_t         sel_i,
  output logic                             pin_o,
  output logic                             active_o
);

  // null and unused codes land on tied-low sources, so the pin sees nothing
  always_comb begin
    pin_o    = src_i[sel_i];
    active_o = (sel_i != `ROPS_CODE_NULL);
  end

endmodule

`default_nettype wire

// [rops_pkg.sv]
/*
  types for the remappable output pin select block.
  assumes rops_defs.svh is on the include path.
*/
`include "rops_defs.svh"

package rops_pkg;

  typedef logic [`ROPS_SEL_W-1:0] rops_sel_t;

  typedef struct packed {
    logic       comparator_three_out;
    logic       comparator_two_out;
    logic       comparator_one_out;
    logic [3:0] uart_transmit;
    logic [3:0] uart_request_to_send;
    logic [2:0] spi_data_out;
    logic [2:0] spi_clock_out;
    logic [2:0] spi_select_out;
    logic [8:0] compare_channel;
  } rops_periph_s;

endpackage
